/* File: roic_axis.sv */
module roic_axis
    import roic_pkg::*;
#(
    parameter int W = ROIC_CNT_W
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic restart_i,
    input wire logic finish_i,
    input wire logic raw_i,
    input wire logic [W-1:0] skip_i,
    input wire logic [W-1:0] act_m1_i,
    output logic valid_o,
    output logic inwin_o
);

    typedef struct packed {
        logic [W-1:0] pos;
        logic run;
        logic last;
    } roic_axis_st_t;

    roic_axis_st_t st_reg;
    roic_axis_st_t st_next;
    logic [W-1:0] cur;
    logic [W:0] win_end;
    logic at_end;
    logic live;

    if (W < 2) begin : g_bad_width
        $error("roic_axis needs a counter of at least two bits.");
    end

    always_comb begin
        st_next = st_reg;
        live = raw_i | st_reg.run | restart_i;
        // RULE9 counter restart
        cur = restart_i ? '0 : st_reg.pos;
        win_end = {1'b0, skip_i} + {1'b0, act_m1_i};
        at_end = {1'b0, cur} >= win_end;
        inwin_o = (cur >= skip_i) && ({1'b0, cur} <= win_end);
        if (restart_i) begin
            st_next.run = 1'b1;
            st_next.pos = '0;
            st_next.last = 1'b0;
        end
        if (tick_i && live) begin
            st_next.pos = (cur == {W{1'b1}}) ? cur : cur + 1'b1;
            st_next.last = at_end;
        end
        // RULE2 stretch ends
        if (finish_i && (st_reg.run || restart_i) && ((tick_i && live) ? at_end : st_reg.last)) begin
            st_next.run = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // RULE2 stretched valid
    assign valid_o = raw_i | st_reg.run;

endmodule // roic_axis

/* File: roic_camera.sv */
module roic_camera #(
    parameter int PIX_W = 8
) (
    output logic pixel_clk_o,
    output logic line_valid_o,
    output logic frame_valid_o,
    output logic [PIX_W-1:0] pixel_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // The pixel clock runs free, since stretched lines still need ticks.
    initial begin
        pixel_clk_o = 1'b0;
        line_valid_o = 1'b0;
        frame_valid_o = 1'b0;
        pixel_data_o = '0;
        forever #200 pixel_clk_o = ~pixel_clk_o;
    end
    // Idle pixels carry a changing pattern, never the last value.
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge pixel_clk_o);
            line_valid_o <= 1'b0;
            pixel_data_o <= ~pixel_data_o;
        end
    endtask
    // All lines change mid-period, well clear of the sampling edge.
    task automatic send(input int w, input int h);
        idle(1);
        frame_valid_o <= 1'b1;
        idle(2);
        for (int l = 0; l < h; l++) begin
            for (int p = 0; p < w; p++) begin
                @(negedge pixel_clk_o);
                line_valid_o <= 1'b1;
                pixel_data_o <= PIX_W'(p);
            end
            idle(3);
        end
        frame_valid_o <= 1'b0;
    endtask
endmodule // roic_camera

/* File: roic_checker.sv */
module roic_checker
    import roic_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [ROIC_ADDR_W-1:0] addr_i,
    input wire logic [ROIC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ROIC_DATA_W-1:0] rdata_o,
    input wire logic line_valid_i,
    input wire logic frame_valid_i,
    input wire logic pix_valid_o,
    input wire logic line_valid_o,
    input wire logic frame_valid_o
);
    typedef struct packed {
        logic byp;
        logic [15:0] hs;
        logic [15:0] ha;
        logic [16:0] pc;
    } roic_chk_t;
    roic_chk_t s_reg;
    roic_chk_t s_next;
    // Shadow of the bypass bit and the horizontal window setup, and a count of kept pixels in the current line.
    always_comb begin
        s_next = s_reg;
        if (wr_i && addr_i == ROIC_LINK_CTRL_OFS) s_next.byp = wdata_i[ROIC_CTRL_BYPASS_BIT];
        if (wr_i && addr_i == ROIC_LINE_LEAD_OFS) s_next.hs = wdata_i;
        if (wr_i && addr_i == ROIC_LINE_KEPT_OFS) s_next.ha = wdata_i;
        if (!line_valid_o) s_next.pc = '0;
        else if (pix_valid_o) s_next.pc = s_reg.pc + 17'h1;
        if (rst_i) s_next = {ROIC_BYPASS_RST, ROIC_SKIP_RST, ROIC_ACT_RST, 17'h0};
    end
    always_ff @(posedge clock_i) begin
        s_reg <= s_next;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence quiet_s;
        !pix_valid_o [*6];
    endsequence
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside a read");
    a_wo_read_zero: assert property (rd_i && addr_i[7:3] == 5'h03 && !addr_i[0]
        |=> rdata_o == 16'h0000) else $error("write-only register read back");
    a_single_pulse: assert property (pix_valid_o |=> quiet_s)
        else $error("pixel pulse too long");
    a_pulse_window: assert property (pix_valid_o |-> line_valid_o && frame_valid_o)
        else $error("pixel outside valid");
    a_skip_lead: assert property ($rose(line_valid_o) && !s_reg.byp && s_reg.hs != 16'h0
        |-> quiet_s) else $error("skipped pixel passed");
    a_line_len: assert property ($fell(line_valid_o) && frame_valid_i && !s_reg.byp
        && s_reg.pc != 17'h0 |-> s_reg.pc == {1'b0, s_reg.ha} + 17'h1)
        else $error("wrong kept pixel count");
    a_bypass_drop: assert property (s_reg.byp && $fell(line_valid_i)
        |-> ##[2:14] !line_valid_o) else $error("bypass line not followed");
    a_frame_open: assert property ($rose(frame_valid_i) |-> ##[2:14] frame_valid_o)
        else $error("frame start missed");
endmodule // roic_checker

bind roic_cropper roic_checker chk_u (
    .clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .line_valid_i,
    .frame_valid_i, .pix_valid_o, .line_valid_o, .frame_valid_o
);

/* File: roic_cropper.sv */
module roic_cropper
    import roic_pkg::*;
#(
    parameter int PIX_W = 8
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [ROIC_ADDR_W-1:0] addr_i,
    input wire logic [ROIC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ROIC_DATA_W-1:0] rdata_o,
    input wire logic pixel_clk_i,
    input wire logic line_valid_i,
    input wire logic frame_valid_i,
    input wire logic [PIX_W-1:0] pixel_data_i,
    output logic [PIX_W-1:0] pix_data_o,
    output logic pix_valid_o,
    output logic line_valid_o,
    output logic frame_valid_o
);

    localparam int SYNC_W = PIX_W + 3;

    typedef struct packed {
        logic pclk_prev;
        logic lv_prev;
        logic fv_prev;
        logic lint_prev;
        logic fint_prev;
        logic keep;
        logic [ROIC_CNT_W-1:0] line_lead_pixels;
        logic [ROIC_CNT_W-1:0] line_kept_pixels_m1;
        logic [ROIC_CNT_W-1:0] frame_lead_lines;
        logic [ROIC_CNT_W-1:0] frame_kept_lines_m1;
        logic crop_bypass;
        logic [ROIC_DATA_W-1:0] frames;
        logic [ROIC_DATA_W-1:0] rdata;
        logic [PIX_W-1:0] data;
        logic pvld;
        logic lvo;
        logic fvo;
    } roic_main_st_t;

    roic_main_st_t st_reg;
    roic_main_st_t st_next;

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic pclk_s;
    logic lv_s;
    logic fv_s;
    logic [PIX_W-1:0] data_s;
    logic pix_tick;
    logic lv_rise;
    logic fv_rise;
    logic h_valid;
    logic h_inwin;
    logic v_valid;
    logic v_inwin;
    logic h_restart;
    logic v_restart;
    logic synth_line;
    logic line_end;
    logic line_now;
    logic keep_now;
    logic [ROIC_DATA_W-1:0] status_word;

    if (PIX_W < 1) begin : g_bad_pix
        $error("roic_cropper needs a pixel width of at least one.");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Camera pins enter the system clock domain.
    ////////////////////////////////////////////////////////////////////////////

    assign sync_in = {pixel_clk_i, line_valid_i, frame_valid_i, pixel_data_i};

    roic_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .d_i(sync_in),
        .q_o(sync_out)
    );

    assign pclk_s = sync_out[SYNC_W-1];
    assign lv_s = sync_out[SYNC_W-2];
    assign fv_s = sync_out[SYNC_W-3];
    assign data_s = sync_out[PIX_W-1:0];

    // The pixel clock is far slower than the system clock, so each of its
    // rising edges becomes a one-cycle tick; all pins share one sync depth.
    assign pix_tick = pclk_s & ~st_reg.pclk_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Window counters.
    ////////////////////////////////////////////////////////////////////////////

    // RULE9 edge detection
    assign lv_rise = lv_s & ~st_reg.lv_prev;
    assign fv_rise = fv_s & ~st_reg.fv_prev;

    // A stretched frame whose camera frame has ended gets lines of its own,
    // one after another, so the vertical count can still run out.
    assign synth_line = v_valid & ~fv_s & ~h_valid & ~line_end;
    assign h_restart = pix_tick & (lv_rise | synth_line);
    assign v_restart = pix_tick & fv_rise;
    assign line_end = pix_tick & st_reg.lint_prev & ~h_valid;

    // RULE4 leading pixels
    // RULE5 kept pixels
    roic_axis #(
        .W(ROIC_CNT_W)
    ) u_horizontal (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .tick_i(pix_tick),
        .restart_i(h_restart),
        .finish_i(pix_tick),
        .raw_i(lv_s),
        .skip_i(st_reg.line_lead_pixels),
        .act_m1_i(st_reg.line_kept_pixels_m1),
        .valid_o(h_valid),
        .inwin_o(h_inwin)
    );

    // RULE6 leading lines
    // RULE7 kept lines
    roic_axis #(
        .W(ROIC_CNT_W)
    ) u_vertical (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .tick_i(h_restart),
        .restart_i(v_restart),
        .finish_i(line_end),
        .raw_i(fv_s),
        .skip_i(st_reg.frame_lead_lines),
        .act_m1_i(st_reg.frame_kept_lines_m1),
        .valid_o(v_valid),
        .inwin_o(v_inwin)
    );

    assign line_now = h_valid | h_restart;
    assign keep_now = h_restart ? v_inwin : st_reg.keep;

    assign status_word = ROIC_DATA_W'({st_reg.crop_bypass, st_reg.fvo, st_reg.lvo});

    ////////////////////////////////////////////////////////////////////////////
    // Next state.
    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_next = st_reg;
        st_next.pclk_prev = pclk_s;
        st_next.pvld = 1'b0;
        st_next.rdata = ROIC_RDATA_IDLE;

        if (pix_tick) begin
            st_next.lv_prev = lv_s;
            st_next.fv_prev = fv_s;
            st_next.lint_prev = h_valid;
            st_next.fint_prev = v_valid;
            if (h_restart) begin
                st_next.keep = v_inwin;
            end
            st_next.data = data_s;
            if (st_reg.crop_bypass) begin
                // RULE1 bypass path
                st_next.lvo = lv_s;
                st_next.fvo = fv_s;
                st_next.pvld = lv_s & fv_s;
            end else begin
                // RULE1 cropping path
                st_next.fvo = v_valid | v_restart;
                st_next.lvo = line_now & (v_valid | v_restart);
                // RULE9 both windows
                st_next.pvld = line_now & h_inwin & keep_now & (v_valid | v_restart);
            end
            if (st_reg.fint_prev && !v_valid) begin
                st_next.frames = st_reg.frames + 1'b1;
            end
        end

        if (wr_i) begin
            case (addr_i)
                ROIC_LINE_LEAD_OFS: begin
                    st_next.line_lead_pixels = wdata_i;
                end
                ROIC_LINE_KEPT_OFS: begin
                    st_next.line_kept_pixels_m1 = wdata_i;
                end
                ROIC_FRAME_LEAD_OFS: begin
                    st_next.frame_lead_lines = wdata_i;
                end
                ROIC_FRAME_KEPT_OFS: begin
                    st_next.frame_kept_lines_m1 = wdata_i;
                end
                ROIC_LINK_CTRL_OFS: begin
                    st_next.crop_bypass = wdata_i[ROIC_CTRL_BYPASS_BIT];
                end
                default: begin
                    st_next.crop_bypass = st_reg.crop_bypass;
                end
            endcase
        end

        // RULE3 write-only window
        if (rd_i) begin
            case (addr_i)
                ROIC_LINK_CTRL_OFS: begin
                    st_next.rdata = ROIC_DATA_W'(st_reg.crop_bypass) << ROIC_CTRL_BYPASS_BIT;
                end
                ROIC_STATUS_OFS: begin
                    st_next.rdata = status_word;
                end
                ROIC_FRAMES_OFS: begin
                    st_next.rdata = st_reg.frames;
                end
                default: begin
                    st_next.rdata = ROIC_RDATA_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.line_lead_pixels <= ROIC_SKIP_RST;
            st_reg.line_kept_pixels_m1 <= ROIC_ACT_RST;
            st_reg.frame_lead_lines <= ROIC_SKIP_RST;
            st_reg.frame_kept_lines_m1 <= ROIC_ACT_RST;
            st_reg.crop_bypass <= ROIC_BYPASS_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;
    assign pix_data_o = st_reg.data;
    assign pix_valid_o = st_reg.pvld;
    assign line_valid_o = st_reg.lvo;
    assign frame_valid_o = st_reg.fvo;

endmodule // roic_cropper

/* File: roic_pkg.sv */
// Overview of operation
// RULE1 - Crop while the bypass bit of link control is clear; bypass when set.
// RULE2 - Stretch line-valid and frame-valid until the programmed active counts run out.
// RULE3 - The four window registers are 16-bit, write-only; reads return zero.
// RULE4 - Drop the horizontal skip count of pixels at each line start (0x18).
// RULE5 - Then pass horizontal active plus one pixels per line (0x1a).
// RULE6 - Drop the vertical skip count of whole lines at each frame start (0x1c).
// RULE7 - Then pass vertical active plus one lines per frame (0x1e).
// RULE8 - Software programs zero skips and full size minus one for the whole image.
// RULE9 - Counters restart on valid rising edges; pixels valid only inside both windows.
package roic_pkg;

    localparam int ROIC_ADDR_W = 8;
    localparam int ROIC_DATA_W = 16;
    localparam int ROIC_CNT_W = 16;

    // Register offsets.
    localparam logic [ROIC_ADDR_W-1:0] ROIC_LINE_LEAD_OFS = 8'h18;
    localparam logic [ROIC_ADDR_W-1:0] ROIC_LINE_KEPT_OFS = 8'h1a;
    localparam logic [ROIC_ADDR_W-1:0] ROIC_FRAME_LEAD_OFS = 8'h1c;
    localparam logic [ROIC_ADDR_W-1:0] ROIC_FRAME_KEPT_OFS = 8'h1e;
    localparam logic [ROIC_ADDR_W-1:0] ROIC_LINK_CTRL_OFS = 8'h29;
    localparam logic [ROIC_ADDR_W-1:0] ROIC_STATUS_OFS = 8'h2a;
    localparam logic [ROIC_ADDR_W-1:0] ROIC_FRAMES_OFS = 8'h2c;

    // Field positions.
    localparam int ROIC_CTRL_BYPASS_BIT = 3;
    localparam int ROIC_STAT_LINE_BIT = 0;
    localparam int ROIC_STAT_FRAME_BIT = 1;
    localparam int ROIC_STAT_BYPASS_BIT = 2;

    // Reset values: the window passes a whole frame up to the counter range.
    localparam logic [ROIC_CNT_W-1:0] ROIC_SKIP_RST = 16'h0000;
    localparam logic [ROIC_CNT_W-1:0] ROIC_ACT_RST = 16'hffff;
    localparam logic ROIC_BYPASS_RST = 1'b0;
    localparam logic [ROIC_DATA_W-1:0] ROIC_RDATA_IDLE = 16'h0000;

endpackage

/* File: roic_sync.sv */
module roic_sync
    import roic_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } roic_sync_st_t;

    roic_sync_st_t st_reg;
    roic_sync_st_t st_next;

    if (W < 1) begin : g_bad_width
        $error("roic_sync needs a width of at least one.");
    end

    always_comb begin
        st_next = st_reg;
        st_next.first = d_i;
        st_next.second = st_reg.first;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_o = st_reg.second;

endmodule // roic_sync

/* File: tb.sv */
module tb
    import roic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i;
    logic rst_i;
    logic [ROIC_ADDR_W-1:0] addr_i;
    logic [ROIC_DATA_W-1:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [ROIC_DATA_W-1:0] rdata_o;
    logic pixel_clk_i;
    logic line_valid_i;
    logic frame_valid_i;
    logic [7:0] pixel_data_i;
    logic [7:0] pix_data_o;
    logic pix_valid_o;
    logic line_valid_o;
    logic frame_valid_o;
    int n_fail;
    int tests_run;
    int npix;
    int psum;
    logic [15:0] rd_word;
    logic [7:0] ofs [5] = '{ROIC_LINE_LEAD_OFS, ROIC_LINE_KEPT_OFS, ROIC_FRAME_LEAD_OFS,
        ROIC_FRAME_KEPT_OFS, 8'h20};
    // Bypass, line_lead_pixels, line_kept_pixels_m1, frame_lead_lines, frame_kept_lines_m1, width, height, pulses, data sum (-1 unchecked).
    int rows [5][9] = '{
        '{0, 2, 3, 1, 1, 8, 4, 8, 28},
        '{0, 0, 7, 0, 3, 8, 4, 32, 112},
        '{1, 3, 0, 2, 0, 6, 3, 18, 45},
        '{0, 1, 7, 1, 3, 6, 3, 32, -1},
        '{0, 0, 0, 0, 0, 3, 2, 1, 0}
    };
    roic_camera cam_u (
        .pixel_clk_o(pixel_clk_i),
        .line_valid_o(line_valid_i),
        .frame_valid_o(frame_valid_i),
        .pixel_data_o(pixel_data_i)
    );
    roic_cropper dut_u (
        .clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pixel_clk_i,
        .line_valid_i, .frame_valid_i, .pixel_data_i, .pix_data_o, .pix_valid_o,
        .line_valid_o, .frame_valid_o
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd_zero(input logic [7:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, 32'h0, "write-only read");
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [7:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        rd_word = rdata_o;
        @(posedge clock_i);
    endtask
    task automatic settle();
        int k;
        for (k = 0; k < 4000; k++) begin
            @(posedge clock_i);
            if (k >= 40 && frame_valid_o === 1'b0) break;
        end
        if (k == 4000) begin
            n_fail++;
            conclude();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (pix_valid_o === 1'b1) begin
            npix++;
            psum += int'(pix_data_o);
        end
    end
    initial begin
        rst_i = 1'b1;
        addr_i = '0;
        wdata_i = '0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (6) @(posedge clock_i);
        chk({rdata_o, pix_valid_o, line_valid_o, frame_valid_o}, 32'h0, "reset");
        rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        foreach (ofs[i]) begin
            wr(ofs[i], 16'ha5c3);
            rd_zero(ofs[i]);
        end
        foreach (rows[i]) begin
            wr(ROIC_LINK_CTRL_OFS, {12'h000, rows[i][0] != 0, 3'h0});
            wr(ROIC_LINE_LEAD_OFS, 16'(rows[i][1]));
            wr(ROIC_LINE_KEPT_OFS, 16'(rows[i][2]));
            wr(ROIC_FRAME_LEAD_OFS, 16'(rows[i][3]));
            wr(ROIC_FRAME_KEPT_OFS, 16'(rows[i][4]));
            npix = 0;
            psum = 0;
            cam_u.send(rows[i][5], rows[i][6]);
            settle();
            chk(npix, rows[i][7], "kept pixels");
            if (rows[i][8] >= 0) chk(psum, rows[i][8], "kept data");
        end
        // Each row ends exactly one internal frame.
        rd(ROIC_FRAMES_OFS);
        chk(rd_word, 32'($size(rows)), "frame count");
        wr(ROIC_LINK_CTRL_OFS, 16'h0008);
        rd(ROIC_LINK_CTRL_OFS);
        chk(rd_word, 32'h8, "bypass readback");
        rd(ROIC_STATUS_OFS);
        chk(rd_word, 32'h4, "idle status");
        // A second reset in mid-run must clear the bypass bit and the frame count.
        rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(ROIC_LINK_CTRL_OFS);
        chk(rd_word, 32'h0, "bypass after reset");
        rd(ROIC_FRAMES_OFS);
        chk(rd_word, 32'h0, "frames after reset");
        chk({pix_valid_o, line_valid_o, frame_valid_o}, 32'h0, "outputs after reset");
        conclude();
    end
endmodule // tb
